// ---- verilog/qmon_pkg.sv ----
/*
  Constants for the event queue watermark monitor: register offsets,
  field positions, reset values and encodings.
  Assumes a 32-bit plain register port with byte addresses.
*/
package qmon_pkg;
  localparam int NUM_QUEUES = 2;
  localparam int CNT_W = 5;
  localparam int PTR_W = 4;
  localparam int ADDR_W = 8;
  // Register byte offsets
  localparam logic [7:0] OFF_QSTATUS0 = 8'h00;
  localparam logic [7:0] OFF_QSTATUS1 = 8'h04;
  localparam logic [7:0] OFF_THRESH = 8'h08;
  localparam logic [7:0] OFF_ERR = 8'h0C;
  localparam logic [7:0] OFF_ERR_CLR = 8'h10;
  localparam logic [7:0] OFF_INT_MASK = 8'h14;
  // Status register field positions
  localparam int STAT_PTR_LSB = 0;
  localparam int STAT_CNT_LSB = 8;
  localparam int STAT_WM_LSB = 16;
  localparam int STAT_FLAG_BIT = 24;
  // Threshold register fields
  localparam int THR_Q0_LSB = 0;
  localparam int THR_Q1_LSB = 8;
  localparam int THR_STRIDE = 8;
  // Threshold values
  localparam logic [4:0] THR_RESET = 5'h10;
  localparam logic [4:0] THR_DISABLE = 5'h11;
  localparam logic [4:0] QUEUE_DEPTH = 5'h10;
  localparam logic [1:0] MASK_RESET = 2'h0;
  // Bus idle state for the single read-data path
  typedef enum logic [0:0] {
    BUS_IDLE = 1'b0,
    BUS_READ = 1'b1
  } bus_state_t;
endpackage

// ---- verilog/event_queue_watermark_monitor.sv ----
/*
  Event queue watermark monitor: per-queue status, programmable
  thresholds, sticky threshold errors and an error interrupt.
  Assumes fill counts and head pointers arrive synchronous to mclk
  from the queue manager, and a plain one-cycle strobe register port.
  The queue storage itself lives elsewhere; this block only watches
  the fill count and head pointer that the queue manager reports.
  Software is expected to program thresholds 0 to 10h, or 11h to
  turn detection off; reserved codes are kept but never reached.
*/
// Added by the designer: the placing of the registers and the address-and-strobe port.
// How it works
// - Queue 0 flag and error bit set when its count reaches its threshold.
// - Queue 1 flag and error bit set when its count reaches its threshold.
// - A threshold of 11h turns off error detection for that queue.
// - Thresholds reset to 16; software uses 0 to 11h only, higher is reserved.
// - The status flag clears when one is written to the queue clear bit, unless its count still meets the threshold.
// - The watermark holds the highest occupancy since reset or clear.
// - Writing the queue clear bit also loads the watermark with the live count.
// - The count field shows live queue occupancy from 0 to 10h.
// - The pointer field shows the live head entry index 0 to Fh.
// - Each queue holds at most 16 entries.
`timescale 1ns/1ps
module event_queue_watermark_monitor
  import qmon_pkg::*;
#(
  parameter int QUEUES = NUM_QUEUES
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // Queue manager state
  input wire logic [QUEUES*CNT_W-1:0] valid_entry_count,
  input wire logic [QUEUES*PTR_W-1:0] head_entry_pointer,
  // Register port
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [31:0] reg_rdata,
  // Error outputs
  output logic [QUEUES-1:0] queue_threshold_error_bit,
  output logic error_irq
);

  // Elaboration checks: the map carries two status words and two fields
  if (QUEUES != NUM_QUEUES) begin : g_bad_queues
    $error("QUEUES must be 2");
  end
  // A count field must reach a full queue
  if ((1 << CNT_W) <= int'(QUEUE_DEPTH)) begin : g_bad_cnt_w
    $error("CNT_W too narrow for the queue depth");
  end
  // The head pointer must index every entry
  if ((1 << PTR_W) < int'(QUEUE_DEPTH)) begin : g_bad_ptr_w
    $error("PTR_W too narrow for the queue depth");
  end
  // Threshold fields must not overlap
  if (THR_STRIDE < CNT_W) begin : g_bad_stride
    $error("THR_STRIDE narrower than a threshold field");
  end
  // Second threshold field sits one stride above the first
  if (THR_Q1_LSB - THR_Q0_LSB != THR_STRIDE) begin : g_bad_thr_pos
    $error("threshold field positions disagree with the stride");
  end
  // Status fields must not overlap
  if (STAT_PTR_LSB + PTR_W > STAT_CNT_LSB) begin : g_bad_ptr_field
    $error("pointer field runs into the count field");
  end
  if (STAT_CNT_LSB + CNT_W > STAT_WM_LSB) begin : g_bad_cnt_field
    $error("count field runs into the watermark field");
  end
  if (STAT_WM_LSB + CNT_W > STAT_FLAG_BIT) begin : g_bad_wm_field
    $error("watermark field runs into the flag bit");
  end
  // Offsets up to 14h need at least five address bits
  if (ADDR_W < 5) begin : g_bad_addr_w
    $error("ADDR_W too narrow for the register map");
  end

  // Per-queue state
  logic [CNT_W-1:0] thresh_q [QUEUES];
  logic [CNT_W-1:0] thresh_d [QUEUES];
  logic [CNT_W-1:0] wm_q [QUEUES];
  logic [CNT_W-1:0] wm_d [QUEUES];
  logic [QUEUES-1:0] flag_q;
  logic [QUEUES-1:0] flag_d;
  logic [QUEUES-1:0] err_q;
  logic [QUEUES-1:0] err_d;
  logic [QUEUES-1:0] clr_hit;
  logic [QUEUES-1:0] over;
  logic [31:0] stat_word [QUEUES];

  // Shared register state
  logic [QUEUES-1:0] mask_q;
  logic [31:0] thr_word;
  logic [31:0] err_word;
  logic [31:0] mask_word;
  logic [31:0] rdata_d;
  logic irq_d;

  // Address decode, one hit line per mapped register
  logic hit_stat0;
  logic hit_stat1;
  logic hit_thr;
  logic hit_err;
  logic hit_clr;
  logic hit_mask;
  logic wr_thr;
  logic wr_clr;
  logic wr_mask;
  logic [QUEUES-1:0] clr_bits;

  // Full-width compares, so aliases of a short map never hit
  assign hit_stat0 = (reg_addr == OFF_QSTATUS0);
  assign hit_stat1 = (reg_addr == OFF_QSTATUS1);
  assign hit_thr = (reg_addr == OFF_THRESH);
  assign hit_err = (reg_addr == OFF_ERR);
  assign hit_clr = (reg_addr == OFF_ERR_CLR);
  assign hit_mask = (reg_addr == OFF_INT_MASK);

  // Write qualifiers; unmapped writes change nothing
  assign wr_thr = reg_write && hit_thr;
  assign wr_clr = reg_write && hit_clr;
  assign wr_mask = reg_write && hit_mask;

  // clear bits count only beside the clear strobe
  assign clr_bits = wr_clr ? reg_wdata[QUEUES-1:0] : '0;

  // One copy of the compare, watermark and flags per queue.
  // Counts are live inputs, so a flag can set in the very cycle
  // that software clears it; the set is kept so no event is lost.
  genvar g;
  generate
    for (g = 0; g < QUEUES; g++) begin : g_q
      // five count bits cover 0 to 16 entries
      logic [CNT_W-1:0] cnt;
      logic [PTR_W-1:0] ptr;
      logic thr_off;
      logic thr_met;

      // Live queue manager fields
      assign cnt = valid_entry_count[g*CNT_W +: CNT_W];
      assign ptr = head_entry_pointer[g*PTR_W +: PTR_W];
      assign clr_hit[g] = clr_bits[g];
      assign thr_off = (thresh_q[g] == THR_DISABLE);
      // count equal to or above threshold
      assign thr_met = (cnt >= thresh_q[g]);
      assign over[g] = thr_met && !thr_off;

      // next threshold; reserved codes kept, no count can meet them
      always_comb begin
        thresh_d[g] = thresh_q[g];
        if (wr_thr) begin
          thresh_d[g] = reg_wdata[g*THR_STRIDE +: CNT_W];
        end
      end

      // threshold field, defaults to a full queue
      always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
          thresh_q[g] <= THR_RESET;
        end else begin
          thresh_q[g] <= thresh_d[g];
        end
      end

      // next watermark; the clear loads the live count
      always_comb begin
        wm_d[g] = wm_q[g];
        if (clr_hit[g]) begin
          wm_d[g] = cnt; // Occupancy at the clear still counts
        end else if (cnt > wm_q[g]) begin
          wm_d[g] = cnt;
        end
      end

      always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
          wm_q[g] <= '0;
        end else begin
          wm_q[g] <= wm_d[g];
        end
      end

      // next flag and error bit, set wins over a clear
      assign flag_d[g] = over[g] | (flag_q[g] & ~clr_hit[g]);
      assign err_d[g] = over[g] | (err_q[g] & ~clr_hit[g]);

      always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
          flag_q[g] <= 1'b0;
        end else begin
          flag_q[g] <= flag_d[g];
        end
      end

      // error register bit, kept apart from the flag
      always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
          err_q[g] <= 1'b0;
        end else begin
          err_q[g] <= err_d[g];
        end
      end

      always_comb begin
        stat_word[g] = '0;
        stat_word[g][STAT_PTR_LSB +: PTR_W] = ptr;
        stat_word[g][STAT_CNT_LSB +: CNT_W] = cnt;
        stat_word[g][STAT_WM_LSB +: CNT_W] = wm_q[g];
        stat_word[g][STAT_FLAG_BIT] = flag_q[g];
      end
    end
  endgenerate

  // Interrupt mask, same layout as the error register
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      mask_q <= MASK_RESET;
    end else if (wr_mask) begin
      mask_q <= reg_wdata[QUEUES-1:0];
    end
  end

  always_comb begin
    thr_word = '0;
    thr_word[THR_Q0_LSB +: CNT_W] = thresh_q[0];
    thr_word[THR_Q1_LSB +: CNT_W] = thresh_q[1];
  end

  always_comb begin
    err_word = '0;
    err_word[QUEUES-1:0] = err_q;
  end

  always_comb begin
    mask_word = '0;
    mask_word[QUEUES-1:0] = mask_q;
  end

  // read mux; the clear register is write-only and reads zero.
  // Status words are built from live inputs, so a read shows the
  // queue as it stood at the strobe edge, not one cycle later.
  always_comb begin
    rdata_d = '0;
    if (hit_stat0) begin
      rdata_d = stat_word[0];
    end else if (hit_stat1) begin
      rdata_d = stat_word[1];
    end else if (hit_thr) begin
      rdata_d = thr_word;
    end else if (hit_err) begin
      rdata_d = err_word;
    end else if (hit_mask) begin
      rdata_d = mask_word;
    end
  end

  // Read data stands one cycle after the strobe, zero otherwise.
  // Zeroing idle cycles lets several slaves share an OR bus.
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      reg_rdata <= '0;
    end else if (reg_read) begin
      reg_rdata <= rdata_d;
    end else begin
      reg_rdata <= '0;
    end
  end

  // Interrupt level from unmasked error bits
  assign irq_d = |(err_q & mask_q);

  // Error bits to the pins, one cycle behind the register
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      queue_threshold_error_bit <= '0;
    end else begin
      queue_threshold_error_bit <= err_q;
    end
  end

  // Interrupt level, registered so the pin comes from a flop
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      error_irq <= 1'b0;
    end else begin
      error_irq <= irq_d;
    end
  end

endmodule // event_queue_watermark_monitor

// ---- test/qmon_asserts.sv ----
/* Port checker for the queue monitor.
   Assumes one clock, thresholds written only via the register port. */
`timescale 1ns/1ps
module qmon_asserts
  import qmon_pkg::*;
#(parameter int QUEUES = NUM_QUEUES) (
  // Clock and inputs
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic [QUEUES*CNT_W-1:0] valid_entry_count,
  input wire logic [QUEUES*PTR_W-1:0] head_entry_pointer,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  // Outputs
  input wire logic [31:0] reg_rdata,
  input wire logic [QUEUES-1:0] queue_threshold_error_bit,
  input wire logic error_irq
);
  default clocking @(posedge mclk); endclocking
  default disable iff (sys_rst);
  logic [12:0] thr_q;
  wire k0 = reg_write && reg_addr == OFF_ERR_CLR && reg_wdata[0];
  wire rs0 = reg_read && reg_addr == OFF_QSTATUS0;
  wire [4:0] c0 = valid_entry_count[4:0];
  wire [4:0] c1 = valid_entry_count[9:5];
  // Shadow thresholds, reserved bits dropped
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) thr_q <= 13'h1010;
    else if (reg_write && reg_addr == OFF_THRESH) thr_q <= reg_wdata[12:0] & 13'h1F1F;
  end
  // Output lags the error register by one cycle
  sequence s_hit0; c0 >= thr_q[4:0] && thr_q[4:0] != THR_DISABLE; endsequence
  sequence s_hit1; c1 >= thr_q[12:8] && thr_q[12:8] != THR_DISABLE; endsequence
  AST_Q0_SET: assert property (s_hit0 |-> ##2 queue_threshold_error_bit[0])
    else $error("queue 0 error not set");
  AST_Q1_SET: assert property (s_hit1 |-> ##2 queue_threshold_error_bit[1])
    else $error("queue 1 error not set");
  AST_STICKY: assert property (!k0 ##1 queue_threshold_error_bit[0] |=> queue_threshold_error_bit[0])
    else $error("error dropped without clear");
  AST_PTR: assert property (rs0 |=> reg_rdata[3:0] == $past(head_entry_pointer[3:0]))
    else $error("bad head pointer");
  AST_CNT: assert property (rs0 |=> reg_rdata[12:8] == $past(c0))
    else $error("bad entry count");
  AST_RSVD: assert property (rs0 |=> (reg_rdata & 32'hFEE0E0F0) == 32'h0)
    else $error("reserved status bits set");
  AST_WM: assert property (rs0 |=> reg_rdata[20:16] >= $past(c0, 2) && reg_rdata[20:16] <= QUEUE_DEPTH)
    else $error("bad watermark");
  AST_THR: assert property (reg_read && reg_addr == OFF_THRESH |=> reg_rdata == {19'h0, thr_q})
    else $error("bad threshold readback");
  AST_CLR0: assert property (k0 && !(c0 >= thr_q[4:0] && thr_q[4:0] != THR_DISABLE) |-> ##2 !queue_threshold_error_bit[0])
    else $error("queue 0 error not cleared");
  AST_RD_IDLE: assert property (!reg_read |=> reg_rdata == 32'h0)
    else $error("read data outside its cycle");
endmodule // qmon_asserts
bind event_queue_watermark_monitor qmon_asserts #(.QUEUES(QUEUES)) u_chk (.mclk, .sys_rst,
  .valid_entry_count, .head_entry_pointer, .reg_addr, .reg_wdata, .reg_write, .reg_read,
  .reg_rdata, .queue_threshold_error_bit, .error_irq);

// ---- test/tb_event_queue_watermark_monitor.sv ----
/* Self-checking bench for the queue monitor.
   Assumes the checker is bound from its own file. */
`timescale 1ns/1ps
module tb_event_queue_watermark_monitor
  import qmon_pkg::*;
();
  logic mclk = 0, sys_rst = 1, reg_write = 0, reg_read = 0, rd_d = 0, irq;
  logic [9:0] cnt = 0;
  logic [7:0] ptr = 0, reg_addr = 0, p = 0;
  logic [31:0] reg_wdata = 0, reg_rdata, exq[$];
  logic [1:0] err;
  int num_errors = 0, checks_done = 0;
  always #20 mclk = ~mclk;
  event_queue_watermark_monitor DUT (.mclk, .sys_rst, .valid_entry_count(cnt),
    .head_entry_pointer(ptr), .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata,
    .queue_threshold_error_bit(err), .error_irq(irq));
  task chk(input logic [31:0] s, input logic [31:0] e);
    checks_done++;
    if (s !== e) begin
      num_errors++;
      $display("mismatch at %0t: saw %h want %h", $time, s, e);
    end
  endtask
  task rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge mclk);
    reg_read <= 1;
    reg_addr <= a;
    exq.push_back(e);
    @(posedge mclk);
    reg_read <= 0;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    reg_write <= 1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_write <= 0;
  endtask
  function logic [31:0] st(input logic [4:0] c, input logic [4:0] w, input logic f);
    return {7'h0, f, 3'h0, w, 3'h0, c, 4'h0, p[3:0]};
  endfunction
  task print_verdict;
    $display("errors %0d checks %0d", num_errors, checks_done);
    if (num_errors == 0 && checks_done > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // Read data settles one cycle after the strobe
  always @(posedge mclk) rd_d <= reg_read;
  always @(negedge mclk) if (rd_d) chk(reg_rdata, exq.pop_front());
  // Hang guard, well beyond the short sequence
  initial begin
    #20000;
    num_errors++;
    print_verdict;
  end
  initial begin
    void'($urandom(15517));
    repeat (2) @(posedge mclk);
    sys_rst <= 0;
    rd(OFF_THRESH, 32'h1010);
    rd(8'h3C, 32'h0);
    p = 8'($urandom);
    ptr <= p;
    cnt <= 10'h005;
    repeat (2) @(posedge mclk);
    rd(OFF_QSTATUS0, st(5'h05, 5'h05, 0));
    wr(OFF_THRESH, 32'h1103);
    wr(OFF_INT_MASK, 32'h1);
    cnt <= 10'h203;
    repeat (3) @(posedge mclk);
    rd(OFF_QSTATUS0, st(5'h03, 5'h05, 1));
    rd(OFF_ERR, 32'h1);
    @(negedge mclk);
    chk({29'h0, err, irq}, 32'h3);
    @(posedge mclk);
    cnt <= 10'h200;
    wr(OFF_ERR_CLR, 32'h1);
    repeat (3) @(posedge mclk);
    rd(OFF_QSTATUS0, st(5'h00, 5'h00, 0));
    @(negedge mclk);
    chk({29'h0, err, irq}, 32'h0);
    wr(OFF_THRESH, 32'hFFFFF0E0);
    repeat (3) @(posedge mclk);
    rd(OFF_THRESH, 32'h1000);
    @(negedge mclk);
    chk({29'h0, err, irq}, 32'h7);
    rd(OFF_QSTATUS1, {7'h0, 1'b1, 3'h0, 5'h10, 3'h0, 5'h10, 4'h0, p[7:4]});
    wr(OFF_INT_MASK, 32'h0);
    repeat (2) @(posedge mclk);
    @(negedge mclk);
    chk({29'h0, err, irq}, 32'h6);
    print_verdict;
  end
endmodule // tb_event_queue_watermark_monitor
